// File: shared/pport_pkg.sv
// Package with offsets, fields, reset values, modes and timing of the parallel port register file.
package pport_pkg;
    // Register offsets relative to the selected base; bit 10 selects the upper bank.
    localparam logic [10:0] OFF_DATA = 11'h000;
    localparam logic [10:0] OFF_STATUS = 11'h001;
    localparam logic [10:0] OFF_CONTROL = 11'h002;
    localparam logic [10:0] OFF_FIFO = 11'h400;
    localparam logic [10:0] OFF_CFG_B = 11'h401;
    localparam logic [10:0] OFF_MODE = 11'h402;
    localparam logic [9:0] REG_SPAN = 10'h003;
    // Selectable base addresses.
    localparam logic [9:0] BASE_0 = 10'h3bc;
    localparam logic [9:0] BASE_1 = 10'h278;
    localparam logic [9:0] BASE_2 = 10'h378;
    // Operating modes held in the mode field.
    typedef enum logic [2:0] {
        MODE_STD = 3'b000,
        MODE_BYTE = 3'b001,
        MODE_COMPAT = 3'b010,
        MODE_EXT = 3'b011,
        MODE_TEST = 3'b110,
        MODE_CFG = 3'b111
    } mode_t;
    // Field positions of line_control and mode_control_ext.
    localparam int CTL_DIR = 5;
    localparam int CTL_ACK_IE = 4;
    localparam int CTL_SELIN = 3;
    localparam int CTL_INIT = 2;
    localparam int CTL_AUTOFD = 1;
    localparam int CTL_STROBE = 0;
    localparam int MODE_LSB = 5;
    localparam int MODE_FULL = 1;
    localparam int MODE_EMPTY = 0;
    // Reset values.
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h04;
    localparam logic [7:0] MODE_RST = 8'h00;
    // Configuration A: 16-bit port word, full flag does not count the word held by the transmitter.
    localparam logic [7:0] CFG_A_VAL = 8'h04;
    // Least data setup time before the write pulse.
    localparam int CLK_NS = 20;
    localparam int SETUP_NS = 500;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    // Transmitter states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SETUP = 2'b01,
        TX_STROBE = 2'b10
    } tx_state_t;
endpackage

// File: verilog/port_word_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module port_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    wire [AW-1:0] wr_nx = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    wire [AW-1:0] rd_nx = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;

    // Full and empty come straight from the fill count.
    assign in_ready_o = cnt_q != (AW + 1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];

    // Storage is written without reset.
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // Pointers and count; a clear empties the queue.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || clear_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_nx;
            if (pop) rd_q <= rd_nx;
            if (push && !pop) cnt_q <= cnt_q + 1'b1;
            else if (pop && !push) cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// File: verilog/pport_regs.sv
// Register file, bus decode and forward FIFO transmitter of the parallel port.
`timescale 1ns/1ps
module pport_regs #(
    parameter int FIFO_DEPTH = 8,
    parameter int FIFO_WIDTH = 17
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] base_sel_i,
    input wire logic [10:0] isa_addr_i,
    input wire logic [15:0] isa_data_i,
    output logic [15:0] isa_data_o,
    output logic isa_data_oe_n_o,
    input wire logic io_rd_n_i,
    input wire logic io_wr_n_i,
    output logic io_cs16_n_o,
    output logic dma_req_o,
    input wire logic dma_ack_n_i,
    output logic irq_o,
    input wire logic [7:0] pdata_i,
    output logic [7:0] pdata_o,
    output logic pdata_oe_n_o,
    input wire logic busy_i,
    input wire logic peripheral_ack_n_i,
    input wire logic paper_error_line_i,
    input wire logic select_i,
    input wire logic peripheral_fault_n_i,
    output logic write_pulse_line_n_o,
    output logic write_pulse_line_n_oe_n_o,
    output logic auto_feed_line_n_o,
    output logic auto_feed_line_n_oe_n_o,
    output logic initialize_line_n_o,
    output logic initialize_line_n_oe_n_o,
    output logic select_in_line_n_o,
    output logic select_in_line_n_oe_n_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic [7:0] data_q, control_q, mode_reg_q, pdata_q;
    logic [15:0] rdata_q;
    logic rd_n_q, wr_n_q, ack_n_q, irq_q;
    pport_pkg::tx_state_t tx_q;
    logic [FIFO_WIDTH-1:0] tx_word_q;
    logic tx_hi_q;
    logic [7:0] cnt_q;

    // Base selection and offset decode relative to the chosen base.
    wire [9:0] base = (base_sel_i == 2'd0) ? pport_pkg::BASE_0 :
                      (base_sel_i == 2'd1) ? pport_pkg::BASE_1 : pport_pkg::BASE_2;
    wire [9:0] rel = isa_addr_i[9:0] - base;
    wire hit = rel < pport_pkg::REG_SPAN;
    wire [10:0] off = {isa_addr_i[10], rel};
    wire dma = !dma_ack_n_i;
    wire rd_take = rd_n_q & !io_rd_n_i;
    wire wr_take = wr_n_q & !io_wr_n_i;

    // Mode, effective direction and selection of the mode-dependent registers.
    wire [2:0] mode = mode_reg_q[pport_pkg::MODE_LSB +: 3];
    wire std_like = (mode == pport_pkg::MODE_STD) || (mode == pport_pkg::MODE_COMPAT);
    wire dir_rev = control_q[pport_pkg::CTL_DIR] & !std_like;
    wire sel_data = hit && off == pport_pkg::OFF_DATA &&
                    (mode == pport_pkg::MODE_STD || mode == pport_pkg::MODE_BYTE);
    wire sel_afifo = hit && off == pport_pkg::OFF_DATA && mode == pport_pkg::MODE_EXT;
    wire sel_status = hit && off == pport_pkg::OFF_STATUS;
    wire sel_ctl = hit && off == pport_pkg::OFF_CONTROL;
    wire sel_mode = hit && off == pport_pkg::OFF_MODE;
    wire fifo_mode = mode == pport_pkg::MODE_COMPAT || mode == pport_pkg::MODE_EXT ||
                     mode == pport_pkg::MODE_TEST;
    wire sel_fifo = (hit && off == pport_pkg::OFF_FIFO && fifo_mode) || (dma && fifo_mode);
    wire sel_cfg_a = hit && off == pport_pkg::OFF_FIFO && mode == pport_pkg::MODE_CFG;
    wire sel_cfg_b = hit && off == pport_pkg::OFF_CFG_B && mode == pport_pkg::MODE_CFG;

    // The FIFO port is the only word-wide location; all others are bytes.
    assign io_cs16_n_o = !sel_fifo;

    // FIFO fill side: whole words at 0x400 or tagged single bytes at offset 0.
    wire fifo_in_ready, fifo_out_valid;
    wire [FIFO_WIDTH-1:0] fifo_head;
    wire push_word = wr_take && sel_fifo && !dir_rev;
    wire push_tag = wr_take && sel_afifo && !dir_rev;
    wire [FIFO_WIDTH-1:0] fifo_in = push_tag ? {1'b1, 8'h00, isa_data_i[7:0]}
                                             : {1'b0, isa_data_i};
    wire test_pop = rd_take && sel_fifo && mode == pport_pkg::MODE_TEST;
    wire tx_en = (mode == pport_pkg::MODE_COMPAT || mode == pport_pkg::MODE_EXT) && !dir_rev;
    wire tx_load = tx_q == pport_pkg::TX_IDLE && tx_en && fifo_out_valid;
    wire mode_wr = wr_take && sel_mode;
    wire [2:0] new_mode = isa_data_i[pport_pkg::MODE_LSB +: 3];
    wire fifo_clear = mode_wr && (new_mode == pport_pkg::MODE_STD || new_mode == pport_pkg::MODE_BYTE);

    port_word_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clear_i(fifo_clear),
        .in_valid_i(push_word | push_tag),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(tx_load | test_pop),
        .out_data_o(fifo_head)
    );

    // DMA asks for a word only while the FIFO can take one.
    assign dma_req_o = fifo_mode && !dir_rev && fifo_in_ready && mode != pport_pkg::MODE_TEST;

    // Read multiplexer; unmapped offsets read as zero.
    wire [7:0] status_val = {~busy_i, peripheral_ack_n_i, paper_error_line_i, select_i,
                             peripheral_fault_n_i, 3'b000};
    wire [7:0] ctl_val = {2'b00, control_q[5:0]};
    wire [7:0] mode_val = {mode_reg_q[7:2], !fifo_in_ready, !fifo_out_valid};
    wire [15:0] rmux = sel_data ? {8'h00, pdata_i} :
                       sel_status ? {8'h00, status_val} :
                       sel_ctl ? {8'h00, ctl_val} :
                       sel_mode ? {8'h00, mode_val} :
                       sel_fifo ? fifo_head[15:0] :
                       sel_cfg_a ? {8'h00, pport_pkg::CFG_A_VAL} :
                       sel_cfg_b ? {8'h00, 1'b0, irq_q, 6'b000000} : 16'h0000;
    assign isa_data_o = rdata_q;
    assign isa_data_oe_n_o = io_rd_n_i || !(hit || dma);

    // Command edges are taken on the clock; no wait state exists at all.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rdata_q <= 16'h0000;
        end else begin
            rd_n_q <= io_rd_n_i;
            wr_n_q <= io_wr_n_i;
            if (rd_take) rdata_q <= rmux;
        end
    end

    // Software-written registers.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            data_q <= pport_pkg::DATA_RST;
            control_q <= pport_pkg::CONTROL_RST;
            mode_reg_q <= pport_pkg::MODE_RST;
        end else begin
            if (wr_take && sel_data) data_q <= isa_data_i[7:0];
            if (wr_take && sel_ctl) control_q <= isa_data_i[7:0];
            if (mode_wr) mode_reg_q <= isa_data_i[7:0];
        end
    end

    // Acknowledge edge detection gives a one-cycle interrupt pulse.
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ack_n_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            ack_n_q <= peripheral_ack_n_i;
            irq_q <= control_q[pport_pkg::CTL_ACK_IE] & !ack_n_q & peripheral_ack_n_i;
        end
    end
    assign irq_o = irq_q;

    // Transmitter: set up the byte, wait for busy low, strobe until busy rises.
    wire setup_done = cnt_q >= 8'(pport_pkg::SETUP_CYC - 1);
    wire single = tx_word_q[16];
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_q <= pport_pkg::TX_IDLE;
            tx_word_q <= '0;
            tx_hi_q <= 1'b0;
            cnt_q <= 8'h00;
        end else begin
            case (tx_q)
                pport_pkg::TX_IDLE: begin
                    cnt_q <= 8'h00;
                    tx_hi_q <= 1'b0;
                    if (tx_load) begin
                        tx_word_q <= fifo_head;
                        tx_q <= pport_pkg::TX_SETUP;
                    end
                end
                pport_pkg::TX_SETUP: begin
                    if (!setup_done) cnt_q <= cnt_q + 8'h01;
                    else if (!busy_i) tx_q <= pport_pkg::TX_STROBE;
                end
                pport_pkg::TX_STROBE: begin
                    if (busy_i) begin
                        cnt_q <= 8'h00;
                        if (!tx_hi_q && !single) begin
                            tx_hi_q <= 1'b1;
                            tx_q <= pport_pkg::TX_SETUP;
                        end else begin
                            tx_q <= pport_pkg::TX_IDLE;
                        end
                    end
                end
                default: tx_q <= pport_pkg::TX_IDLE;
            endcase
        end
    end

    // Data lines: the transmitter's byte while active, else the data register.
    wire tx_act = tx_q != pport_pkg::TX_IDLE;
    wire [7:0] tx_byte = tx_hi_q ? tx_word_q[15:8] : tx_word_q[7:0];
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) pdata_q <= 8'h00;
        else pdata_q <= tx_act ? tx_byte : data_q;
    end
    assign pdata_o = pdata_q;
    assign pdata_oe_n_o = dir_rev;

    // Control lines; register bits force the line active over the machine.
    wire hw_strobe = tx_q == pport_pkg::TX_STROBE;
    wire hw_autofd = tx_act && single && mode == pport_pkg::MODE_EXT;
    wire [3:0] line_val = {~control_q[pport_pkg::CTL_SELIN], control_q[pport_pkg::CTL_INIT],
                           ~(control_q[pport_pkg::CTL_AUTOFD] | hw_autofd),
                           ~(control_q[pport_pkg::CTL_STROBE] | hw_strobe)};
    wire [3:0] line_oe_n;
    for (genvar i = 0; i < 4; i++) begin : g_line
        // Open-collector drives only lows in mode 000; push-pull elsewhere.
        assign line_oe_n[i] = (mode == pport_pkg::MODE_STD) ? line_val[i] : 1'b0;
    end
    assign write_pulse_line_n_o = line_val[0];
    assign auto_feed_line_n_o = line_val[1];
    assign initialize_line_n_o = line_val[2];
    assign select_in_line_n_o = line_val[3];
    assign write_pulse_line_n_oe_n_o = line_oe_n[0];
    assign auto_feed_line_n_oe_n_o = line_oe_n[1];
    assign initialize_line_n_oe_n_o = line_oe_n[2];
    assign select_in_line_n_oe_n_o = line_oe_n[3];

    // Word indication only for the FIFO location in a FIFO mode.
    cs16_word_a: assert property (!io_cs16_n_o |-> fifo_mode && (off == pport_pkg::OFF_FIFO || dma))
        else $error("16-bit indication outside the FIFO location");
    // Status read returns the input levels seen at the take edge.
    status_read_a: assert property (rd_take && sel_status |=> rdata_q[7:3] ==
        {~$past(busy_i), $past(peripheral_ack_n_i), $past(paper_error_line_i), $past(select_i),
         $past(peripheral_fault_n_i)} && rdata_q[2:0] == 3'b000)
        else $error("status read does not mirror inputs");
    // Data register read returns the line value, not the stored byte.
    data_read_a: assert property (rd_take && sel_data |=> rdata_q[7:0] == $past(pdata_i))
        else $error("data read differs from line value");
    // Strobe forced low by the control bit in any mode.
    strobe_force_a: assert property (control_q[pport_pkg::CTL_STROBE] |-> !write_pulse_line_n_o)
        else $error("strobe not forced by control bit");
    // A control write reaches the initialize line a cycle later, uninverted.
    init_write_a: assert property (wr_take && sel_ctl |=> initialize_line_n_o == $past(isa_data_i[2]))
        else $error("initialize line does not follow control bit");
    // In mode 000 a high line is released, never driven.
    open_coll_a: assert property (mode == pport_pkg::MODE_STD && select_in_line_n_o |->
        select_in_line_n_oe_n_o) else $error("open-collector line driven high");
    // Reverse direction in byte mode releases the data lines.
    dir_release_a: assert property (mode == pport_pkg::MODE_BYTE && control_q[pport_pkg::CTL_DIR] |->
        pdata_oe_n_o) else $error("data drivers on in reverse direction");
    // Acknowledge rising edge with interrupt enabled pulses on the next cycle.
    ack_irq_a: assert property (control_q[pport_pkg::CTL_ACK_IE] && $rose(peripheral_ack_n_i) |->
        ##1 irq_o) else $error("acknowledge edge gave no interrupt");
    // Strobe only follows a completed setup phase.
    strobe_setup_a: assert property ($rose(hw_strobe) |-> $past(tx_q) == pport_pkg::TX_SETUP &&
        $past(setup_done)) else $error("strobe without data setup");
    // The request drops as soon as the FIFO cannot take another word.
    dreq_full_a: assert property (!fifo_in_ready |-> !dma_req_o)
        else $error("DMA request while FIFO full");
    // Byte-wide registers never claim a 16-bit transfer.
    cs16_byte_a: assert property (!dma && (sel_status || sel_ctl || sel_mode) |-> io_cs16_n_o)
        else $error("16-bit indication on a byte register");
    // Reserved control bits read back as zero.
    ctl_reserved_a: assert property (rd_take && sel_ctl |=> rdata_q[7:6] == 2'b00)
        else $error("reserved control bits not zero");
    // With the enable clear no interrupt pulse follows.
    irq_off_a: assert property (!control_q[pport_pkg::CTL_ACK_IE] |=> !irq_o)
        else $error("interrupt while acknowledge interrupt disabled");
    // An address or count entry is strobed with the auto-feed line low.
    afd_tag_a: assert property (hw_strobe && single && mode == pport_pkg::MODE_EXT |->
        !auto_feed_line_n_o) else $error("tagged entry strobed without auto-feed");
    // Outside mode 000 the write pulse line is always driven.
    push_pull_a: assert property (mode != pport_pkg::MODE_STD |-> !write_pulse_line_n_oe_n_o)
        else $error("control line released outside mode 000");
endmodule

// File: test/pport_peripheral.sv
// Peripheral model that takes bytes on the write pulse and paces them with busy.
`timescale 1ns/1ps
module pport_peripheral (
    input wire logic ref_clk_i,
    input wire logic stall_i,
    input wire logic [2:0] hold_i,
    input wire logic write_pulse_line_n_i,
    input wire logic auto_feed_line_n_i,
    input wire logic [7:0] pdata_i,
    output logic busy_o
);
    logic [8:0] rx_q[$];
    logic busy_q = 1'b0;
    logic [2:0] hold_q = 3'h0;
    // A stalled peripheral keeps busy high whatever the host does.
    assign busy_o = busy_q | stall_i;
    // Latch byte and address flag on the asserting edge, then release busy after a delay.
    always @(posedge ref_clk_i) begin
        if (!busy_o && !write_pulse_line_n_i) begin
            rx_q.push_back({auto_feed_line_n_i, pdata_i});
            busy_q <= 1'b1;
            hold_q <= hold_i;
        end else if (busy_q && write_pulse_line_n_i && !stall_i) begin
            if (hold_q == 3'h0) busy_q <= 1'b0;
            else hold_q <= hold_q - 3'h1;
        end
    end
endmodule

// File: test/parallel_port_isa_register_file_tb.sv
// Self-checking bench for the parallel port register file.
`timescale 1ns/1ps
module parallel_port_isa_register_file_tb;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [1:0] base_sel = 2'h0;
    logic [10:0] addr = 11'h0;
    logic [15:0] wdata = 16'h0;
    logic rd_n = 1'b1, wr_n = 1'b1, dack_n = 1'b1, stall = 1'b0;
    logic [7:0] periph_data = 8'h0;
    logic [3:0] stat = 4'hf;
    logic [2:0] hold = 3'h2;
    logic [2:0] cur_mode = 3'h0;
    logic [15:0] rdata;
    logic [7:0] pdata_o, pdata_in;
    logic doe_n, cs16_n, dreq, irq, pdata_oe_n, busy;
    logic stb_n, stb_oe, afd_n, afd_oe, ini_n, ini_oe, sin_n, sin_oe;
    int fail_count = 0;
    int checks_done = 0;
    logic [8:0] exp_q[$];

    // The data lines carry the port's byte unless the peripheral drives them.
    assign pdata_in = pdata_oe_n ? periph_data : pdata_o;
    always #10 ref_clk_i = ~ref_clk_i;

    pport_regs DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .base_sel_i(base_sel), .isa_addr_i(addr),
        .isa_data_i(wdata), .isa_data_o(rdata), .isa_data_oe_n_o(doe_n), .io_rd_n_i(rd_n), .io_wr_n_i(wr_n),
        .io_cs16_n_o(cs16_n), .dma_req_o(dreq), .dma_ack_n_i(dack_n), .irq_o(irq), .pdata_i(pdata_in),
        .pdata_o(pdata_o), .pdata_oe_n_o(pdata_oe_n), .busy_i(busy), .peripheral_ack_n_i(stat[3]),
        .paper_error_line_i(stat[2]), .select_i(stat[1]), .peripheral_fault_n_i(stat[0]),
        .write_pulse_line_n_o(stb_n), .write_pulse_line_n_oe_n_o(stb_oe), .auto_feed_line_n_o(afd_n),
        .auto_feed_line_n_oe_n_o(afd_oe), .initialize_line_n_o(ini_n), .initialize_line_n_oe_n_o(ini_oe),
        .select_in_line_n_o(sin_n), .select_in_line_n_oe_n_o(sin_oe));

    pport_peripheral per (.ref_clk_i(ref_clk_i), .stall_i(stall), .hold_i(hold), .write_pulse_line_n_i(stb_n),
        .auto_feed_line_n_i(afd_n), .pdata_i(pdata_in), .busy_o(busy));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // One host cycle: command low for three edges, answer taken, then released.
    task automatic access(input logic wr, input logic [10:0] off, input logic [15:0] d, input logic dma,
                          input logic [1:0] sel, output logic [15:0] q);
        @(posedge ref_clk_i);
        addr <= {off[10], ((sel == 2'h0) ? pport_pkg::BASE_0 : (sel == 2'h1) ? pport_pkg::BASE_1
                 : pport_pkg::BASE_2) + off[9:0]};
        wdata <= d;
        dack_n <= ~dma;
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        @(posedge ref_clk_i);
        #1 check({15'h0, cs16_n}, {15'h0, !((off == pport_pkg::OFF_FIFO || dma) && cur_mode inside {3'h2, 3'h3, 3'h6})});
        check({15'h0, doe_n}, {15'h0, wr || !(dma || (sel == base_sel && off[9:0] < pport_pkg::REG_SPAN))});
        @(posedge ref_clk_i);
        #1 q = rdata;
        @(posedge ref_clk_i);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        dack_n <= 1'b1;
    endtask

    task automatic wr(input logic [10:0] off, input logic [15:0] d);
        logic [15:0] q;
        access(1'b1, off, d, 1'b0, base_sel, q);
    endtask

    task automatic rd_check(input logic [10:0] off, input logic [15:0] exp);
        logic [15:0] q;
        access(1'b0, off, 16'h0, 1'b0, base_sel, q);
        check(q, exp);
    endtask

    task automatic set_mode(input logic [2:0] m);
        wr(pport_pkg::OFF_CONTROL, 16'h0004);
        wr(pport_pkg::OFF_MODE, {8'h0, m, 5'h0});
        cur_mode = m;
    endtask

    task automatic check_lines(input logic [7:0] c);
        logic [3:0] v;
        v = {~c[3], c[2], ~c[1], ~c[0]};
        check({12'h0, sin_n, ini_n, afd_n, stb_n}, {12'h0, v});
        check({12'h0, sin_oe, ini_oe, afd_oe, stb_oe}, {12'h0, (cur_mode == 3'h0) ? v : 4'h0});
    endtask

    task automatic wait_rx(input int n);
        int t;
        t = 0;
        while (per.rx_q.size() < n && t < 8000) begin
            @(posedge ref_clk_i);
            t++;
        end
        repeat (100) @(posedge ref_clk_i);
        check(per.rx_q.size(), n);
        foreach (exp_q[i]) check({7'h0, per.rx_q[i]}, {7'h0, exp_q[i]});
    endtask

    task automatic ack_pulse(input logic [15:0] exp);
        int n;
        n = 0;
        @(posedge ref_clk_i) stat[3] <= 1'b0;
        @(posedge ref_clk_i) stat[3] <= 1'b1;
        repeat (6) begin
            @(posedge ref_clk_i);
            #1 n += irq;
        end
        check(n[15:0], exp);
    endtask

    // Watchdog that cuts a hung run short.
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        fail_count++;
        print_verdict();
    end

    // Main sequence of tests.
    initial begin
        logic [7:0] c;
        logic [15:0] w, q;
        int k;
        void'($urandom(32'h7d19d0e2));
        base_sel = $urandom % 3;
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd_check(pport_pkg::OFF_CONTROL, {8'h0, pport_pkg::CONTROL_RST});
        rd_check(pport_pkg::OFF_MODE, 16'h0001);
        check_lines(pport_pkg::CONTROL_RST);
        rd_check(11'h003, 16'h0000);
        access(1'b0, pport_pkg::OFF_CONTROL, 16'h0, 1'b0, (base_sel == 2'h0) ? 2'h1 : 2'h0, q);
        check(q, 16'h0000);
        $display("test reset_decode done");
        for (k = 0; k < 12; k++) begin
            set_mode(k[1:0]);
            c = $urandom & 8'h1f;
            wr(pport_pkg::OFF_CONTROL, {8'h0, c});
            rd_check(pport_pkg::OFF_CONTROL, {8'h0, c});
            check_lines(c);
            @(posedge ref_clk_i) stat <= $urandom;
            repeat (3) @(posedge ref_clk_i);
            rd_check(pport_pkg::OFF_STATUS, {8'h0, ~busy, stat, 3'h0});
        end
        $display("test control_status done");
        set_mode(3'h0);
        w = $urandom;
        wr(pport_pkg::OFF_DATA, w);
        check({8'h0, pdata_o}, {8'h0, w[7:0]});
        rd_check(pport_pkg::OFF_DATA, {8'h0, w[7:0]});
        wr(pport_pkg::OFF_CONTROL, 16'h0024);
        check({15'h0, pdata_oe_n}, 16'h0000);
        set_mode(3'h1);
        wr(pport_pkg::OFF_CONTROL, 16'h0024);
        check({15'h0, pdata_oe_n}, 16'h0001);
        c = $urandom;
        periph_data <= c;
        rd_check(pport_pkg::OFF_DATA, {8'h0, c});
        $display("test data_direction done");
        wr(pport_pkg::OFF_CONTROL, 16'h0014);
        ack_pulse(16'h0001);
        wr(pport_pkg::OFF_CONTROL, 16'h0004);
        ack_pulse(16'h0000);
        $display("test interrupt done");
        set_mode(3'h2);
        per.rx_q.delete();
        exp_q.delete();
        stall <= 1'b1;
        hold <= $urandom % 5;
        @(posedge ref_clk_i);
        check({15'h0, dreq}, 16'h0001);
        for (k = 0; k < 12; k++) begin
            w = $urandom;
            access(1'b1, pport_pkg::OFF_FIFO, w, k[0], base_sel, q);
            exp_q.push_back({1'b1, w[7:0]});
            exp_q.push_back({1'b1, w[15:8]});
            access(1'b0, pport_pkg::OFF_MODE, 16'h0, 1'b0, base_sel, q);
            if (q[pport_pkg::MODE_FULL]) break;
        end
        check({15'h0, k inside {7, 8}}, 16'h0001);
        check({15'h0, dreq}, 16'h0000);
        wr(pport_pkg::OFF_FIFO, $urandom);
        stall <= 1'b0;
        wait_rx(exp_q.size());
        rd_check(pport_pkg::OFF_MODE, 16'h0041);
        $display("test compat_fifo done");
        set_mode(3'h3);
        per.rx_q.delete();
        exp_q.delete();
        c = 8'h80 | $urandom;
        wr(pport_pkg::OFF_DATA, {8'h0, c});
        exp_q.push_back({1'b0, c});
        c = $urandom & 8'h7f;
        wr(pport_pkg::OFF_DATA, {8'h0, c});
        exp_q.push_back({1'b0, c});
        w = $urandom;
        wr(pport_pkg::OFF_FIFO, w);
        exp_q.push_back({1'b1, w[7:0]});
        exp_q.push_back({1'b1, w[15:8]});
        wait_rx(4);
        $display("test ext_fifo done");
        set_mode(3'h6);
        w = $urandom;
        c = $urandom;
        wr(pport_pkg::OFF_FIFO, w);
        wr(pport_pkg::OFF_FIFO, {c, 8'h5a});
        check({15'h0, dreq}, 16'h0000);
        rd_check(pport_pkg::OFF_FIFO, w);
        rd_check(pport_pkg::OFF_FIFO, {c, 8'h5a});
        rd_check(pport_pkg::OFF_MODE, 16'h00c1);
        $display("test test_fifo done");
        set_mode(3'h7);
        rd_check(pport_pkg::OFF_FIFO, {8'h0, pport_pkg::CFG_A_VAL});
        rd_check(pport_pkg::OFF_CFG_B, 16'h0000);
        $display("test config done");
        print_verdict();
    end
endmodule
